// >>> common/pmm_consts.svh
// constants of the program memory map decoder
// What this block does
// - each location is 24 bits: lower word plus upper word with missing top byte
// - lower word sits at an even address, upper word at the next odd one
// - program counter stays even and moves by two
// - addresses zero up to 000200h hold fixed vectors, not ordinary code
// - every reset starts execution at 000000h; software keeps a jump there
// - two vector tables: 000004h-0000FFh and 000104h-0001FFh, one entry per source
// - data EEPROM decoded at the top of user space from 7FFE00
// - data EEPROM holds 256 words of 16 bits
// - data EEPROM reached only by table reads and table writes
// - eight configuration words at F80000, then F80004 up to F80010 in steps of two
// - the missing upper byte always reads as zero
// - control and key registers clear only on power-on reset
// - unimplemented bits of control and key registers read as zero
// - high table read in word mode: upper byte low, upper data byte zero
// - low table read in byte mode: byte select picks upper or lower byte
`ifndef PMM_CONSTS_SVH
`define PMM_CONSTS_SVH

`define PMM_RESET_ADDR 24'h000000
`define PMM_IVT_LO 24'h000004
`define PMM_IVT_HI 24'h0000ff
`define PMM_AIVT_LO 24'h000104
`define PMM_AIVT_HI 24'h0001ff
`define PMM_CODE_LO 24'h000200
`define PMM_EE_LO 24'h7ffe00
`define PMM_EE_HI 24'h7fffff
`define PMM_CFG_FIRST 24'hf80000
`define PMM_CFG_SECOND 24'hf80004
`define PMM_CFG_LAST 24'hf80010
`define PMM_CFG_RST 16'hffff

`define PMM_NVM_CONTROL_OFS 16'h0760
`define PMM_NVM_UNLOCK_KEY_OFS 16'h0766
`define PMM_NVM_CONTROL_RST 16'h0000
`define PMM_NVM_UNLOCK_KEY_RST 16'h0000
`define PMM_NVM_CONTROL_MASK 16'hf07f
`define PMM_NVM_UNLOCK_KEY_MASK 16'h00ff
`define PMM_BIT_WR 15
`define PMM_BIT_WREN 14
`define PMM_BIT_WRERR 13
`define PMM_KEY_FIRST 8'h55
`define PMM_KEY_SECOND 8'haa

`define PMM_BUSY_NS 320
`define PMM_CLK_MHZ 25

`endif

// >>> common/pmm_pkg.sv
// types of the program memory map decoder
package pmm_pkg;

  typedef enum logic [7:0] {
    PMM_RG_RESET = 8'h01,
    PMM_RG_IVT = 8'h02,
    PMM_RG_AIVT = 8'h04,
    PMM_RG_RSVD = 8'h08,
    PMM_RG_CODE = 8'h10,
    PMM_RG_EE = 8'h20,
    PMM_RG_CFG = 8'h40,
    PMM_RG_NONE = 8'h80
  } pmm_region_t;

  typedef enum logic [1:0] {
    PMM_OP_READ_LOW = 2'h0,
    PMM_OP_READ_HIGH = 2'h1,
    PMM_OP_WRITE_LOW = 2'h2,
    PMM_OP_WRITE_HIGH = 2'h3
  } pmm_op_t;

  typedef struct packed {
    logic valid;
    pmm_op_t op;
    logic byte_mode;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pmm_tbl_req_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [15:0] data;
  } pmm_tbl_rsp_t;

endpackage

// >>> rtl/pmm_ram.sv
// single-port memory with registered read data
`timescale 1ns/10ps
module pmm_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_mask,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data_reg
);
  logic [WIDTH-1:0] mem [DEPTH];

  // array itself has no reset; contents model nonvolatile cells
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= (mem[addr] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= mem[addr];
    end
  end
endmodule // pmm_ram

// >>> rtl/pmm_region.sv
// address to region decode for fetch and table paths
`timescale 1ns/10ps
`include "pmm_consts.svh"
module pmm_region #(
  parameter int PM_WORDS = 1024
) (
  input wire logic [23:0] addr,
  output pmm_pkg::pmm_region_t region,
  output logic [2:0] cfg_idx
);
  import pmm_pkg::*;
  localparam logic [23:0] CODE_END = 24'(PM_WORDS * 2);
  logic [23:0] cfg_ofs;

  always_comb begin
    cfg_ofs = addr - `PMM_CFG_FIRST;
    cfg_idx = 3'h0;
    region = PMM_RG_NONE;
    if (addr < `PMM_IVT_LO) begin
      region = PMM_RG_RESET;
    end else if (addr <= `PMM_IVT_HI) begin
      region = PMM_RG_IVT;
    end else if (addr >= `PMM_AIVT_LO && addr <= `PMM_AIVT_HI) begin
      region = PMM_RG_AIVT;
    end else if (addr < `PMM_CODE_LO) begin
      region = PMM_RG_RSVD;
    end else if (addr < CODE_END) begin
      region = PMM_RG_CODE;
    end else if (addr >= `PMM_EE_LO && addr <= `PMM_EE_HI) begin
      region = PMM_RG_EE;
    end else if (addr[23:1] == `PMM_CFG_FIRST >> 1) begin
      region = PMM_RG_CFG;
    end else if (addr >= `PMM_CFG_SECOND && addr <= (`PMM_CFG_LAST | 24'h000001)) begin
      region = PMM_RG_CFG;
      cfg_idx = 3'(cfg_ofs[3:1] - 3'h1);
    end
  end
endmodule // pmm_region

// >>> rtl/pmm_decoder.sv
// program memory map decoder: pc, table access, eeprom, config words, nvm registers
`timescale 1ns/10ps
`include "pmm_consts.svh"
module pmm_decoder #(
  parameter int PM_WORDS = 1024,
  parameter int PM_AW = 10,
  parameter int EE_WORDS = 256,
  parameter int EE_AW = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sys_rst_req,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire pmm_pkg::pmm_tbl_req_t tbl_req,
  output pmm_pkg::pmm_tbl_rsp_t tbl_rsp,
  input wire logic pc_step,
  input wire logic pc_back,
  input wire logic pc_load,
  input wire logic [23:0] pc_target,
  output logic [23:0] pc,
  output pmm_pkg::pmm_region_t pc_region,
  output logic nvm_busy
);
  import pmm_pkg::*;

  localparam int BUSY_CYC_RAW = (`PMM_BUSY_NS * `PMM_CLK_MHZ) / 1000;
  localparam int BUSY_CYC = (BUSY_CYC_RAW < 1) ? 1 : BUSY_CYC_RAW;
  localparam logic [23:0] PC_INC = 24'h000002;

  // program counter
  logic [23:0] pc_reg;
  logic [23:0] pc_next;
  pmm_region_t pc_region_reg;
  pmm_region_t pc_region_next;

  // nvm registers
  logic [15:0] nvm_control_reg;
  logic [15:0] nvm_unlock_key_reg;
  logic unlock_armed_reg;
  logic unlocked_reg;
  logic [15:0] busy_cnt_reg;
  logic [15:0] reg_rdata_reg;

  // table path
  pmm_region_t tbl_region;
  logic [2:0] tbl_cfg_idx;
  logic [15:0] cfg_reg [8];
  logic is_write;
  logic is_high;
  logic wr_ok;
  logic pm_wr;
  logic ee_wr;
  logic [23:0] pm_mask;
  logic [23:0] pm_wdata;
  logic [23:0] pm_rdata;
  logic [15:0] ee_rdata;
  logic [PM_AW-1:0] pm_idx;
  logic [EE_AW-1:0] ee_idx;

  logic st_valid_reg;
  pmm_op_t st_op_reg;
  logic st_byte_reg;
  logic st_bsel_reg;
  logic st_fault_reg;
  pmm_region_t st_region_reg;
  logic [15:0] st_cfg_reg;
  pmm_tbl_rsp_t tbl_rsp_reg;
  logic [23:0] word24;
  logic [15:0] fmt_data;

  pmm_region #(
    .PM_WORDS(PM_WORDS)
  ) u_pc_dec (
    .addr(pc_next),
    .region(pc_region_next),
    .cfg_idx()
  );

  pmm_region #(
    .PM_WORDS(PM_WORDS)
  ) u_tbl_dec (
    .addr(tbl_req.addr),
    .region(tbl_region),
    .cfg_idx(tbl_cfg_idx)
  );

  // pc update: even only, moves in steps of two
  always_comb begin
    pc_next = pc_reg;
    if (sys_rst_req) begin
      pc_next = `PMM_RESET_ADDR;
    end else if (pc_load) begin
      pc_next = {pc_target[23:1], 1'b0};
    end else if (pc_step) begin
      pc_next = pc_reg + PC_INC;
    end else if (pc_back) begin
      pc_next = pc_reg - PC_INC;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= `PMM_RESET_ADDR;
      pc_region_reg <= PMM_RG_RESET;
    end else begin
      pc_reg <= pc_next;
      pc_region_reg <= pc_region_next;
    end
  end

  // key sequence arms a single write start; other resets leave it alone
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_unlock_key_reg <= `PMM_NVM_UNLOCK_KEY_RST;
      unlock_armed_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `PMM_NVM_UNLOCK_KEY_OFS) begin
      nvm_unlock_key_reg <= reg_wdata & `PMM_NVM_UNLOCK_KEY_MASK;
      unlock_armed_reg <= (reg_wdata[7:0] == `PMM_KEY_FIRST);
      unlocked_reg <= unlock_armed_reg && (reg_wdata[7:0] == `PMM_KEY_SECOND);
    end else if (reg_wr) begin
      unlock_armed_reg <= 1'b0;
      unlocked_reg <= unlocked_reg && reg_addr != `PMM_NVM_CONTROL_OFS;
    end
  end

  // control register: write start needs the key, busy timer clears it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_control_reg <= `PMM_NVM_CONTROL_RST;
      busy_cnt_reg <= '0;
    end else begin
      if (reg_wr && reg_addr == `PMM_NVM_CONTROL_OFS) begin
        nvm_control_reg <= reg_wdata & `PMM_NVM_CONTROL_MASK;
        nvm_control_reg[`PMM_BIT_WR] <= nvm_control_reg[`PMM_BIT_WR]
          | (reg_wdata[`PMM_BIT_WR] & unlocked_reg & reg_wdata[`PMM_BIT_WREN]);
        // software may clear the error flag, but a start refused for want of the key in the same write sets it
        nvm_control_reg[`PMM_BIT_WRERR] <= reg_wdata[`PMM_BIT_WRERR]
          | (reg_wdata[`PMM_BIT_WR] & ~unlocked_reg);
        if (reg_wdata[`PMM_BIT_WR] && unlocked_reg && reg_wdata[`PMM_BIT_WREN]) begin
          busy_cnt_reg <= 16'(BUSY_CYC);
        end
      end else if (busy_cnt_reg != 16'h0000) begin
        busy_cnt_reg <= busy_cnt_reg - 16'h0001;
        if (busy_cnt_reg == 16'h0001) begin
          nvm_control_reg[`PMM_BIT_WR] <= 1'b0;
        end
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_reg <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PMM_NVM_CONTROL_OFS: reg_rdata_reg <= nvm_control_reg;
        `PMM_NVM_UNLOCK_KEY_OFS: reg_rdata_reg <= nvm_unlock_key_reg;
        default: reg_rdata_reg <= '0;
      endcase
    end else begin
      reg_rdata_reg <= '0;
    end
  end

  // table write gating: enable bit set and no start in flight
  always_comb begin
    is_write = tbl_req.op == PMM_OP_WRITE_LOW || tbl_req.op == PMM_OP_WRITE_HIGH;
    is_high = tbl_req.op == PMM_OP_READ_HIGH || tbl_req.op == PMM_OP_WRITE_HIGH;
    wr_ok = tbl_req.valid && is_write && nvm_control_reg[`PMM_BIT_WREN]
      && busy_cnt_reg == 16'h0000;
    pm_idx = tbl_req.addr[PM_AW:1];
    ee_idx = tbl_req.addr[EE_AW:1];
    pm_wr = wr_ok && tbl_region != PMM_RG_EE && tbl_region != PMM_RG_CFG
      && tbl_region != PMM_RG_NONE;
    ee_wr = wr_ok && tbl_region == PMM_RG_EE && !is_high;
    pm_mask = 24'h000000;
    pm_wdata = 24'h000000;
    if (is_high) begin
      pm_mask = 24'hff0000;
      pm_wdata = {tbl_req.wdata[7:0], 16'h0000};
    end else if (tbl_req.byte_mode) begin
      pm_mask = tbl_req.addr[0] ? 24'h00ff00 : 24'h0000ff;
      pm_wdata = {8'h00, tbl_req.wdata[7:0], tbl_req.wdata[7:0]};
    end else begin
      pm_mask = 24'h00ffff;
      pm_wdata = {8'h00, tbl_req.wdata};
    end
  end

  // program words: 24 bits, phantom top byte never stored
  pmm_ram #(
    .WIDTH(24),
    .DEPTH(PM_WORDS),
    .AW(PM_AW)
  ) u_pm (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(pm_wr),
    .wr_mask(pm_mask),
    .addr(pm_idx),
    .wr_data(pm_wdata),
    .rd_data_reg(pm_rdata)
  );

  // eeprom words only behind the table path
  pmm_ram #(
    .WIDTH(16),
    .DEPTH(EE_WORDS),
    .AW(EE_AW)
  ) u_ee (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(ee_wr),
    .wr_mask(tbl_req.byte_mode ? (tbl_req.addr[0] ? 16'hff00 : 16'h00ff) : 16'hffff),
    .addr(ee_idx),
    .wr_data(tbl_req.byte_mode ? {2{tbl_req.wdata[7:0]}} : tbl_req.wdata),
    .rd_data_reg(ee_rdata)
  );

  // configuration words, low word only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        cfg_reg[i] <= `PMM_CFG_RST;
      end
    end else if (wr_ok && tbl_region == PMM_RG_CFG && !is_high) begin
      cfg_reg[tbl_cfg_idx] <= tbl_req.wdata;
    end
  end

  // stage 1: request attributes wait beside the memory read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_valid_reg <= 1'b0;
      st_op_reg <= PMM_OP_READ_LOW;
      st_byte_reg <= 1'b0;
      st_bsel_reg <= 1'b0;
      st_fault_reg <= 1'b0;
      st_region_reg <= PMM_RG_NONE;
      st_cfg_reg <= '0;
    end else begin
      st_valid_reg <= tbl_req.valid;
      st_op_reg <= tbl_req.op;
      st_byte_reg <= tbl_req.byte_mode;
      st_bsel_reg <= tbl_req.addr[0];
      st_region_reg <= tbl_region;
      st_cfg_reg <= cfg_reg[tbl_cfg_idx];
      st_fault_reg <= tbl_region == PMM_RG_NONE
        || (tbl_region == PMM_RG_EE && is_high)
        || (is_write && !wr_ok);
    end
  end

  // stage 2: format data for the requested part and width
  always_comb begin
    word24 = pm_rdata;
    if (st_region_reg == PMM_RG_EE) begin
      word24 = {8'h00, ee_rdata};
    end else if (st_region_reg == PMM_RG_CFG) begin
      word24 = {8'h00, st_cfg_reg};
    end else if (st_region_reg == PMM_RG_NONE) begin
      word24 = 24'h000000;
    end
    fmt_data = 16'h0000;
    if (st_op_reg == PMM_OP_READ_HIGH) begin
      if (!st_byte_reg) begin
        fmt_data = {8'h00, word24[23:16]};
      end else if (!st_bsel_reg) begin
        fmt_data = {8'h00, word24[23:16]};
      end else begin
        fmt_data = 16'h0000;
      end
    end else if (st_op_reg == PMM_OP_READ_LOW) begin
      if (!st_byte_reg) begin
        fmt_data = word24[15:0];
      end else begin
        fmt_data = {8'h00, st_bsel_reg ? word24[15:8] : word24[7:0]};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tbl_rsp_reg <= '0;
    end else begin
      tbl_rsp_reg.valid <= st_valid_reg;
      tbl_rsp_reg.fault <= st_valid_reg && st_fault_reg;
      tbl_rsp_reg.data <= st_valid_reg ? fmt_data : 16'h0000;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign tbl_rsp = tbl_rsp_reg;
  assign pc = pc_reg;
  assign pc_region = pc_region_reg;
  assign nvm_busy = nvm_control_reg[`PMM_BIT_WR];
endmodule // pmm_decoder

// >>> testbench/pmm_decoder_chk_asserts.sv
// port assertions of the program memory map decoder
`timescale 1ns/10ps
`include "pmm_consts.svh"
module pmm_decoder_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sys_rst_req,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire pmm_pkg::pmm_tbl_req_t tbl_req,
  input wire pmm_pkg::pmm_tbl_rsp_t tbl_rsp,
  input wire logic pc_step,
  input wire logic pc_back,
  input wire logic pc_load,
  input wire logic [23:0] pc,
  input wire logic nvm_busy
);
  import pmm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_rsp_two_cyc: assert property (tbl_req.valid |-> ##2 tbl_rsp.valid)
    else $error("table answer missing two cycles after request");
  a_rsp_no_req: assert property (tbl_rsp.valid |-> $past(tbl_req.valid, 2))
    else $error("table answer without request");
  a_pc_even: assert property (!pc[0])
    else $error("pc left lower word alignment");
  a_pc_step: assert property (pc_step && !pc_load && !sys_rst_req |=> pc == $past(pc) + 24'h2)
    else $error("pc did not advance by two");
  a_pc_back: assert property (pc_back && !pc_step && !pc_load && !sys_rst_req
    |=> pc == $past(pc) - 24'h2)
    else $error("pc did not retreat by two");
  a_reset_pc: assert property (sys_rst_req |=> pc == 24'h0)
    else $error("reset did not restart at zero");
  a_phantom_zero: assert property (tbl_rsp.valid && $past(tbl_req.op, 2) == PMM_OP_READ_HIGH
    && !$past(tbl_req.byte_mode, 2) |-> tbl_rsp.data[15:8] == 8'h00)
    else $error("phantom byte not zero");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_ctl_unimpl: assert property ($past(reg_rd) && $past(reg_addr) == `PMM_NVM_CONTROL_OFS
    |-> reg_rdata[11:7] == 5'h00)
    else $error("control unimplemented bits not zero");
  a_key_unimpl: assert property ($past(reg_rd) && $past(reg_addr) == `PMM_NVM_UNLOCK_KEY_OFS
    |-> reg_rdata[15:8] == 8'h00)
    else $error("key unimplemented bits not zero");
  a_busy_len: assert property ($rose(nvm_busy) |-> nvm_busy [*8] ##1 !nvm_busy)
    else $error("write busy length wrong");
endmodule // pmm_decoder_chk
bind pmm_decoder pmm_decoder_chk pmm_decoder_chk_inst (.mclk(mclk), .rst_b(rst_b),
  .sys_rst_req(sys_rst_req), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tbl_req(tbl_req), .tbl_rsp(tbl_rsp), .pc_step(pc_step), .pc_back(pc_back),
  .pc_load(pc_load), .pc(pc), .nvm_busy(nvm_busy));

// >>> testbench/pmm_core_model.sv
// core model issuing table requests
`timescale 1ns/10ps
module pmm_core_model (
  input wire logic mclk,
  input wire logic rst_b,
  output pmm_pkg::pmm_tbl_req_t tbl_req,
  input wire pmm_pkg::pmm_tbl_rsp_t tbl_rsp
);
  import pmm_pkg::*;
  initial begin
    tbl_req = '0;
  end
  // high ops reach the eeprom only when a caller asks for them
  // idle address, data and byte mode are inverted and valid drops, so a stale request never looks valid
  task automatic xfer(input pmm_op_t op, input logic bm, input logic [23:0] a,
                      input logic [15:0] wd, output logic [15:0] rd, output logic flt);
    @(posedge mclk);
    tbl_req <= '{valid: 1'b1, op: op, byte_mode: bm, addr: a, wdata: wd};
    @(posedge mclk);
    tbl_req <= '{valid: 1'b0, op: op, byte_mode: ~bm, addr: ~a, wdata: ~wd};
    @(posedge mclk);
    #1;
    // a missing answer must not pass a compare that expects zero
    rd = tbl_rsp.valid ? tbl_rsp.data : 'x;
    flt = tbl_rsp.valid ? tbl_rsp.fault : 1'bx;
  endtask
endmodule // pmm_core_model

// >>> testbench/pmm_decoder_tb.sv
// self-checking bench of the program memory map decoder
`timescale 1ns/10ps
`include "pmm_consts.svh"
module pmm_decoder_tb;
  import pmm_pkg::*;
  logic mclk, rst_b, sys_rst_req, reg_wr, reg_rd, pc_step, pc_back, pc_load, nvm_busy, f;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d, lo;
  logic [23:0] pc_target, pc, a;
  logic [31:0] seed;
  logic [7:0] hi;
  int fail_count, n_compared;
  pmm_tbl_req_t tbl_req;
  pmm_tbl_rsp_t tbl_rsp;
  pmm_region_t pc_region;
  pmm_region_t rg [7] = '{PMM_RG_IVT, PMM_RG_AIVT, PMM_RG_RSVD, PMM_RG_CODE, PMM_RG_EE,
                          PMM_RG_CFG, PMM_RG_NONE};
  logic [23:0] tg [7] = '{24'h000004, 24'h000104, 24'h000100, 24'h000200, 24'h7ffe00,
                          24'hf80000, 24'ha00000};
  pmm_decoder pmm_decoder_inst (.mclk(mclk), .rst_b(rst_b), .sys_rst_req(sys_rst_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tbl_req(tbl_req), .tbl_rsp(tbl_rsp), .pc_step(pc_step),
    .pc_back(pc_back), .pc_load(pc_load), .pc_target(pc_target), .pc(pc),
    .pc_region(pc_region), .nvm_busy(nvm_busy));
  pmm_core_model pmm_core_model_inst (.mclk(mclk), .rst_b(rst_b), .tbl_req(tbl_req),
    .tbl_rsp(tbl_rsp));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] byte_pick(input logic [15:0] w, input logic sel);
    return sel ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_fault(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t fault %b expected %b", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [15:0] ad, input logic [15:0] wd);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= wd;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~wd;
  endtask
  task automatic reg_read(input logic [15:0] ad, output logic [15:0] rd);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~ad;
    #1;
    rd = reg_rdata;
  endtask
  task automatic pc_op(input logic s, input logic b, input logic l, input logic [23:0] t);
    @(posedge mclk);
    pc_step <= s;
    pc_back <= b;
    pc_load <= l;
    pc_target <= t;
    @(posedge mclk);
    pc_step <= 1'b0;
    pc_back <= 1'b0;
    pc_load <= 1'b0;
    pc_target <= ~t;
    #1;
  endtask
  task automatic tbl(input pmm_op_t op, input logic bm, input logic [23:0] ad,
                     input logic [15:0] wd);
    pmm_core_model_inst.xfer(op, bm, ad, wd, d, f);
  endtask
  initial begin
    {rst_b, sys_rst_req, reg_wr, reg_rd, pc_step, pc_back, pc_load} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    pc_target = '0;
    fail_count = 0;
    n_compared = 0;
    seed = 32'h6f51;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk_val(pc, 24'h0);
    chk_val(24'(pc_region), 24'(PMM_RG_RESET));
    reg_read(`PMM_NVM_CONTROL_OFS, d);
    chk_val(d, `PMM_NVM_CONTROL_RST);
    reg_read(`PMM_NVM_UNLOCK_KEY_OFS, d);
    chk_val(d, `PMM_NVM_UNLOCK_KEY_RST);
    reg_read(16'h0770, d);
    chk_val(d, 24'h0);
    reg_write(`PMM_NVM_CONTROL_OFS, 16'h4fff);
    reg_read(`PMM_NVM_CONTROL_OFS, d);
    chk_val(d, 24'h407f);
    reg_write(`PMM_NVM_CONTROL_OFS, 16'hc000);
    reg_read(`PMM_NVM_CONTROL_OFS, d);
    chk_val(d, 24'h6000);
    pc_op(1'b1, 1'b0, 1'b0, 24'h0);
    @(posedge mclk);
    sys_rst_req <= 1'b1;
    @(posedge mclk);
    sys_rst_req <= 1'b0;
    #1;
    chk_val(pc, 24'h0);
    reg_read(`PMM_NVM_CONTROL_OFS, d);
    chk_val(d[14], 24'h1);
    reg_write(`PMM_NVM_UNLOCK_KEY_OFS, {8'h00, `PMM_KEY_FIRST});
    reg_write(`PMM_NVM_UNLOCK_KEY_OFS, {8'h00, `PMM_KEY_SECOND});
    reg_write(`PMM_NVM_CONTROL_OFS, 16'hc000);
    #1;
    chk_val(nvm_busy, 24'h1);
    for (int n = 0; n <= 20 && nvm_busy !== 1'b0; n++) begin
      if (n == 20) begin
        fail_count++;
        test_done();
      end
      @(posedge mclk);
      #1;
    end
    reg_write(`PMM_NVM_CONTROL_OFS, 16'h4000);
    tbl(PMM_OP_WRITE_LOW, 1'b0, 24'h000002, 16'h0200);
    tbl(PMM_OP_READ_LOW, 1'b0, 24'h000002, 16'h0);
    chk_val(d, 24'h0200);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 24'h0007fe : 24'h000200 + {14'h0, seed[9:1], 1'b0};
      lo = seed[31:16];
      hi = seed[23:16] ^ seed[7:0];
      tbl(PMM_OP_WRITE_LOW, 1'b0, a, lo);
      chk_fault(f, 1'b0);
      tbl(PMM_OP_WRITE_HIGH, 1'b0, a | 24'h1, {8'h00, hi});
      chk_fault(f, 1'b0);
      tbl(PMM_OP_READ_LOW, 1'b0, a, 16'h0);
      chk_val(d, lo);
      tbl(PMM_OP_READ_HIGH, 1'b0, a | 24'h1, 16'h0);
      chk_val(d, {8'h00, hi});
      for (int b = 0; b < 2; b++) begin
        tbl(PMM_OP_READ_LOW, 1'b1, a | 24'(b), 16'h0);
        chk_val(d, byte_pick(lo, b[0]));
        tbl(PMM_OP_READ_HIGH, 1'b1, a | 24'(b), 16'h0);
        chk_val(d, b ? 24'h0 : {16'h0, hi});
      end
    end
    // byte write into the upper half of the lower word keeps the other byte
    tbl(PMM_OP_WRITE_LOW, 1'b1, a | 24'h1, {8'h00, hi});
    tbl(PMM_OP_READ_LOW, 1'b0, a, 16'h0);
    chk_val(d, {8'h00, hi, lo[7:0]});
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      a = 24'h7ffe00 + {15'h0, (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0], 1'b0};
      tbl(PMM_OP_WRITE_LOW, 1'b0, a, seed[15:0]);
      tbl(PMM_OP_READ_LOW, 1'b0, a, 16'h0);
      chk_val(d, seed[15:0]);
      tbl(PMM_OP_READ_HIGH, 1'b0, a | 24'h1, 16'h0);
      chk_fault(f, 1'b1);
    end
    for (int j = 0; j < 8; j++) begin
      tbl(PMM_OP_READ_LOW, 1'b0, (j == 0) ? 24'hf80000 : 24'hf80002 + 24'(2 * j), 16'h0);
      chk_val(d, `PMM_CFG_RST);
    end
    seed = lfsr(seed);
    tbl(PMM_OP_WRITE_LOW, 1'b0, 24'hf80006, seed[15:0]);
    tbl(PMM_OP_READ_LOW, 1'b0, 24'hf80006, 16'h0);
    chk_val(d, {8'h00, seed[15:0]});
    tbl(PMM_OP_READ_LOW, 1'b0, 24'h800000, 16'h0);
    chk_fault(f, 1'b1);
    chk_val(d, 24'h0);
    reg_write(`PMM_NVM_CONTROL_OFS, 16'h0000);
    tbl(PMM_OP_WRITE_LOW, 1'b0, 24'h000300, 16'h1234);
    chk_fault(f, 1'b1);
    pc_op(1'b0, 1'b0, 1'b1, 24'h000200);
    pc_op(1'b1, 1'b0, 1'b0, 24'h0);
    chk_val(pc, 24'h000202);
    pc_op(1'b0, 1'b1, 1'b0, 24'h0);
    chk_val(pc, 24'h000200);
    pc_op(1'b1, 1'b1, 1'b0, 24'h0);
    chk_val(pc, 24'h000202);
    for (int r = 0; r < 7; r++) begin
      pc_op(1'b0, 1'b0, 1'b1, tg[r]);
      @(posedge mclk);
      #1;
      chk_val(24'(pc_region), 24'(rg[r]));
    end
    // power-on reset in mid-run clears what the other reset kept
    reg_write(`PMM_NVM_CONTROL_OFS, 16'h4001);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk_val(pc, 24'h0);
    reg_read(`PMM_NVM_CONTROL_OFS, d);
    chk_val(d, `PMM_NVM_CONTROL_RST);
    reg_read(`PMM_NVM_UNLOCK_KEY_OFS, d);
    chk_val(d, `PMM_NVM_UNLOCK_KEY_RST);
    test_done();
  end
endmodule // pmm_decoder_tb
